//--- pwm_unit.sv
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "pwm_cfg.svh"

module pwm_unit (
  // clock and reset
  input  wire logic           mclk_in,
  input  wire logic           rst_in,
  // register port
  input  wire pwm_pkg::addr_t addr_in,
  input  wire pwm_pkg::byte_t wdata_in,
  input  wire logic           wr_in,
  input  wire logic           rd_in,
  output pwm_pkg::byte_t      rdata_out,
  // shared pin
  input  wire logic           pin_direction_control_in,
  input  wire logic           port_latch_in,
  output logic                pwm_output_pin_out,
  output logic                pwm_output_pin_oe_out
);
  import pwm_pkg::*;

  // register state
  byte_t      limit_q [`NUM_TIMERS];
  byte_t      limit_d [`NUM_TIMERS];
  byte_t      tctl_q  [`NUM_TIMERS];
  byte_t      tctl_d  [`NUM_TIMERS];
  byte_t      duty_write_q;
  byte_t      duty_write_d;
  byte_t      duty_shadow_q;
  byte_t      duty_shadow_d;
  logic [1:0] low2_q;
  logic [1:0] low2_d;
  byte_t      uctl_q;
  byte_t      uctl_d;
  byte_t      tsel_q;
  byte_t      tsel_d;
  byte_t      rdata_q;
  byte_t      rdata_d;
  logic       latch_q;
  logic       latch_d;

  // timer outputs and count write strobes
  logic       period_end [`NUM_TIMERS];
  byte_t      count      [`NUM_TIMERS];
  logic [1:0] ext        [`NUM_TIMERS];
  logic       count_wr   [`NUM_TIMERS];

  // selected time base
  logic       sel;
  logic       sel_end;
  byte_t      sel_limit;
  base_t      time_base;
  base_t      duty_active;
  base_t      duty_next;
  logic       pwm_mode;
  logic       duty_match;

  function automatic logic hit(input addr_t a, input addr_t off);
    hit = (a == off);
  endfunction

  function automatic addr_t off_limit(input int i);
    off_limit = (i == 0) ? `OFF_LIMIT_A : `OFF_LIMIT_B;
  endfunction

  function automatic addr_t off_tctl(input int i);
    off_tctl = (i == 0) ? `OFF_TCTL_A : `OFF_TCTL_B;
  endfunction

  function automatic addr_t off_count(input int i);
    off_count = (i == 0) ? `OFF_COUNT_A : `OFF_COUNT_B;
  endfunction

  function automatic logic ctl_clear(input logic w, input addr_t a,
                                     input byte_t d);
    ctl_clear = w && hit(a, `OFF_UCTL) && (d == `RST_BYTE);
  endfunction

  // two period timers and their registers
  genvar g;
  generate
    for (g = 0; g < `NUM_TIMERS; g++) begin : g_timer
      assign count_wr[g] = wr_in && hit(addr_in, off_count(g));

      period_timer u_timer (
        .mclk_in        (mclk_in),
        .rst_in         (rst_in),
        .limit_in       (limit_q[g]),
        .control_in     (tctl_q[g]),
        .count_wr_in    (count_wr[g]),
        .count_wdata_in (wdata_in),
        .tick_out       (),
        .period_end_out (period_end[g]),
        .count_out      (count[g]),
        .ext_out        (ext[g])
      );

      always_comb begin
        limit_d[g] = limit_q[g];
        tctl_d[g]  = tctl_q[g];
        if (wr_in && hit(addr_in, off_limit(g)))
          limit_d[g] = wdata_in;
        if (wr_in && hit(addr_in, off_tctl(g)))
          tctl_d[g] = wdata_in & `TCTL_MASK;
      end

      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          limit_q[g] <= `RST_LIMIT;
          tctl_q[g]  <= `RST_BYTE;
        end else begin
          limit_q[g] <= limit_d[g];
          tctl_q[g]  <= tctl_d[g];
        end
      end
    end
  endgenerate

  // time base and duty values
  assign sel         = tsel_q[`TSEL_UNIT];
  assign sel_end     = sel ? period_end[1] : period_end[0];
  assign sel_limit   = sel ? limit_q[1] : limit_q[0];
  assign time_base   = sel ? {count[1], ext[1]} : {count[0], ext[0]};
  assign duty_active = {duty_shadow_q, low2_q};
  assign duty_next   = {duty_write_q, uctl_q[`UCTL_DCLO]};
  assign pwm_mode    = (uctl_q[`UCTL_MODE_HI] == `MODE_PWM);
  // a duty beyond the period never matches, so the pin stays high
  assign duty_match  = (time_base == duty_active);

  // software registers and duty buffering
  always_comb begin
    duty_write_d  = duty_write_q;
    duty_shadow_d = duty_shadow_q;
    low2_d        = low2_q;
    uctl_d        = uctl_q;
    tsel_d        = tsel_q;
    if (wr_in && hit(addr_in, `OFF_DUTY_WR))
      duty_write_d = wdata_in;
    if (wr_in && hit(addr_in, `OFF_UCTL))
      uctl_d = wdata_in & `UCTL_MASK;
    if (wr_in && hit(addr_in, `OFF_TSEL))
      tsel_d = wdata_in & `TSEL_MASK;
    if (pwm_mode) begin
      if (sel_end) begin
        duty_shadow_d = duty_write_q;
        low2_d        = uctl_q[`UCTL_DCLO];
      end
    end else if (wr_in && hit(addr_in, `OFF_DUTY_SH)) begin
      duty_shadow_d = wdata_in;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      duty_write_q  <= `RST_BYTE;
      duty_shadow_q <= `RST_BYTE;
      low2_q        <= `RST_LOW2;
      uctl_q        <= `RST_BYTE;
      tsel_q        <= `RST_BYTE;
    end else begin
      duty_write_q  <= duty_write_d;
      duty_shadow_q <= duty_shadow_d;
      low2_q        <= low2_d;
      uctl_q        <= uctl_d;
      tsel_q        <= tsel_d;
    end
  end

  // output latch
  always_comb begin
    latch_d = latch_q;
    if (ctl_clear(wr_in, addr_in, wdata_in))
      latch_d = 1'b0;
    else if (!pwm_mode)
      latch_d = 1'b0;
    else if (sel_end)
      latch_d = (duty_next != '0);
    else if (duty_match)
      latch_d = 1'b0;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in)
      latch_q <= 1'b0;
    else
      latch_q <= latch_d;
  end

  // read port, data one cycle after the strobe
  always_comb begin
    rdata_d = `RST_BYTE;
    if (rd_in) begin
      unique case (addr_in)
        `OFF_LIMIT_A: rdata_d = limit_q[0];
        `OFF_LIMIT_B: rdata_d = limit_q[1];
        `OFF_TCTL_A:  rdata_d = tctl_q[0];
        `OFF_TCTL_B:  rdata_d = tctl_q[1];
        `OFF_COUNT_A: rdata_d = count[0];
        `OFF_COUNT_B: rdata_d = count[1];
        `OFF_DUTY_WR: rdata_d = duty_write_q;
        `OFF_DUTY_SH: rdata_d = duty_shadow_q;
        `OFF_UCTL:    rdata_d = uctl_q;
        `OFF_TSEL:    rdata_d = tsel_q;
        default:      rdata_d = `RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in)
      rdata_q <= `RST_BYTE;
    else
      rdata_q <= rdata_d;
  end

  assign rdata_out = rdata_q;

  // pin mux; the port data latch is never altered here
  // match cycle already low, so high time is duty times base step
  assign pwm_output_pin_out    = pwm_mode ? (latch_q && !duty_match)
                                          : port_latch_in;
  assign pwm_output_pin_oe_out = !pin_direction_control_in;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  AST_SET_HIGH: assert property (
    pwm_mode && sel_end && (duty_next != '0) && !wr_in |=> latch_q)
    else $error("pin not set at period end");

  AST_ZERO_DUTY: assert property (
    pwm_mode && sel_end && (duty_next == '0) |=> !latch_q)
    else $error("pin set with zero duty");

  AST_LATCH_DUTY: assert property (
    pwm_mode && sel_end |=> duty_shadow_q == $past(duty_write_q)
    && low2_q == $past(uctl_q[`UCTL_DCLO]))
    else $error("duty not latched at period end");

  AST_CTRL_ZERO: assert property (
    ctl_clear(wr_in, addr_in, wdata_in)
    |=> !latch_q ##1 !latch_q)
    else $error("latch not forced low by zero control");

  AST_MATCH_LOW: assert property (
    pwm_mode && !sel_end && duty_match && !wr_in |=> !latch_q)
    else $error("pin not cleared on duty match");

  AST_SHADOW_RO: assert property (
    pwm_mode && !sel_end |=> $stable(duty_shadow_q))
    else $error("shadow changed outside period end");

  AST_DEFER: assert property (
    pwm_mode && wr_in && hit(addr_in, `OFF_DUTY_WR) && !sel_end
    |=> duty_active == $past(duty_active))
    else $error("duty write took effect early");

  AST_MODE_OFF: assert property (
    !pwm_mode |=> !latch_q)
    else $error("latch high outside pwm mode");

  AST_HOLD_HIGH: assert property (
    pwm_mode && latch_q && !sel_end && !duty_match && !wr_in
    |=> latch_q)
    else $error("pin dropped without duty match");

  AST_PIN_START: assert property (
    pwm_mode && sel_end && (duty_next != '0) && !wr_in
    |=> pwm_output_pin_out)
    else $error("pin low after period end");

  AST_DUTY_FORM: assert property (
    pwm_mode && sel_end |=> duty_active == $past(duty_next))
    else $error("active duty not byte plus low bits");

  AST_LOW2_HOLD: assert property (
    !(pwm_mode && sel_end) |=> $stable(low2_q))
    else $error("hidden low bits changed mid period");

  AST_NO_MATCH: assert property (
    pwm_mode && latch_q && !sel_end && !wr_in
    && (time_base <= {sel_limit, `EXT_TOP})
    && (duty_active > {sel_limit, `EXT_TOP}) |=> latch_q)
    else $error("pin dropped with duty beyond period");

  AST_PIN_CLEAR: assert property (
    pwm_mode && duty_match |-> !pwm_output_pin_out)
    else $error("pin high during duty match");

  AST_PIN_PORT: assert property (
    !pwm_mode |-> pwm_output_pin_out == port_latch_in)
    else $error("port latch not passed to pin");

  AST_LIMIT_LOAD_A: assert property (
    wr_in && hit(addr_in, `OFF_LIMIT_A) |=> limit_q[0] == $past(wdata_in))
    else $error("period limit A not written");

  AST_LIMIT_LOAD_B: assert property (
    wr_in && hit(addr_in, `OFF_LIMIT_B) |=> limit_q[1] == $past(wdata_in))
    else $error("period limit B not written");

  AST_TCTL_LOAD: assert property (
    wr_in && hit(addr_in, `OFF_TCTL_A)
    |=> tctl_q[0] == ($past(wdata_in) & `TCTL_MASK))
    else $error("timer control A not written");

  AST_DUTY_LOAD: assert property (
    wr_in && hit(addr_in, `OFF_DUTY_WR) |=> duty_write_q == $past(wdata_in))
    else $error("duty write byte not written");

  AST_SHADOW_OPEN: assert property (
    !pwm_mode && wr_in && hit(addr_in, `OFF_DUTY_SH)
    |=> duty_shadow_q == $past(wdata_in))
    else $error("shadow not writable outside pwm mode");

  AST_SHADOW_READ: assert property (
    rd_in && hit(addr_in, `OFF_DUTY_SH)
    |=> rdata_out == $past(duty_shadow_q))
    else $error("shadow read data wrong");

  AST_UCTL_LOAD: assert property (
    wr_in && hit(addr_in, `OFF_UCTL)
    |=> uctl_q == ($past(wdata_in) & `UCTL_MASK))
    else $error("unit control not written");

  AST_TSEL_PICK: assert property (
    wr_in && hit(addr_in, `OFF_TSEL)
    |=> sel == $past(wdata_in[`TSEL_UNIT]))
    else $error("timer choice not written");
endmodule

//--- pwm_cfg.svh
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH

// register offsets on the plain register port
`define ADDR_W         4
`define OFF_LIMIT_A    4'h0
`define OFF_LIMIT_B    4'h1
`define OFF_TCTL_A     4'h2
`define OFF_TCTL_B     4'h3
`define OFF_COUNT_A    4'h4
`define OFF_COUNT_B    4'h5
`define OFF_DUTY_WR    4'h6
`define OFF_DUTY_SH    4'h7
`define OFF_UCTL       4'h8
`define OFF_TSEL       4'h9

// period timer control fields
`define TCTL_CKPS      1:0
`define TCTL_ON        2
`define TCTL_MASK      8'h7F

// unit control fields
`define UCTL_DCLO      5:4
`define UCTL_MODE_HI   3:2
`define UCTL_MASK      8'h3F
`define MODE_PWM       2'h3

// time base select, bit of this unit
`define TSEL_UNIT      3
`define TSEL_MASK      8'h1F

// reset values
`define RST_BYTE       8'h00
`define RST_LIMIT      8'h00
`define RST_LOW2       2'h0
`define RST_SUB        6'h00

// fine counter end values: one less than four phases times the prescale ratio
`define SUB_END_1      6'h03
`define SUB_END_4      6'h0F
`define SUB_END_16     6'h3F
`define SUB_ONE        6'h01
`define COUNT_ONE      8'h01
// top value of the two time base extension bits
`define EXT_TOP        2'h3

`define NUM_TIMERS     2

`endif

//--- pwm_pkg.sv
package pwm_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] addr_t;
  typedef logic [9:0] base_t;
  typedef enum logic [1:0] {
    PRE_1  = 2'b00,
    PRE_4  = 2'b01,
    PRE_16 = 2'b10
  } prescale_t;
endpackage

//--- period_timer.sv
`timescale 1ns/100ps
`include "pwm_cfg.svh"

module period_timer (
  // clock and reset
  input  wire logic           mclk_in,
  input  wire logic           rst_in,
  // configuration
  input  wire pwm_pkg::byte_t limit_in,
  input  wire pwm_pkg::byte_t control_in,
  // software write of the count
  input  wire logic           count_wr_in,
  input  wire pwm_pkg::byte_t count_wdata_in,
  // time base
  output logic                tick_out,
  output logic                period_end_out,
  output pwm_pkg::byte_t      count_out,
  output logic [1:0]          ext_out
);
  import pwm_pkg::*;

  logic [5:0] sub_q;
  logic [5:0] sub_d;
  byte_t      count_q;
  byte_t      count_d;
  logic [5:0] sub_end;
  logic       run;

  // postscaler bits of control_in are never looked at
  assign run = control_in[`TCTL_ON];

  always_comb begin
    unique case (control_in[`TCTL_CKPS])
      PRE_1: begin
        sub_end = `SUB_END_1;
        ext_out = sub_q[1:0];
      end
      PRE_4: begin
        sub_end = `SUB_END_4;
        ext_out = sub_q[3:2];
      end
      default: begin
        sub_end = `SUB_END_16;
        ext_out = sub_q[5:4];
      end
    endcase
  end

  assign tick_out       = run && (sub_q == sub_end);
  assign period_end_out = tick_out && (count_q == limit_in);
  assign count_out      = count_q;

  always_comb begin
    sub_d   = sub_q;
    count_d = count_q;
    if (count_wr_in) begin
      sub_d   = `RST_SUB;
      count_d = count_wdata_in;
    end else if (run) begin
      sub_d = tick_out ? `RST_SUB : sub_q + `SUB_ONE;
      if (period_end_out)
        count_d = `RST_BYTE;
      else if (tick_out)
        count_d = count_q + `COUNT_ONE;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sub_q   <= `RST_SUB;
      count_q <= `RST_BYTE;
    end else begin
      sub_q   <= sub_d;
      count_q <= count_d;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  AST_PRESCALE_4: assert property (
    (control_in[`TCTL_CKPS] == PRE_4) && tick_out && !count_wr_in
    && $stable(control_in) |-> ##1 !tick_out [*3])
    else $error("prescale 4 ticked too early");

  AST_PERIOD_CLEAR: assert property (
    period_end_out && !count_wr_in |=> count_q == `RST_BYTE)
    else $error("count not cleared at period end");
endmodule

//--- test_ccp_pwm_mode_generator.sv
`timescale 1ns/100ps
`include "pwm_cfg.svh"

module test_ccp_pwm_mode_generator;
  import pwm_pkg::*;

  logic  mclk_in;
  logic  rst_in;
  addr_t addr_in;
  byte_t wdata_in;
  logic  wr_in;
  logic  rd_in;
  byte_t rdata_out;
  logic  dir_in;
  logic  port_in;
  logic  pin_out;
  logic  oe_out;
  int    failures;
  int    tests_run;
  int    seed;
  byte_t got;
  byte_t old;

  pwm_unit DUT (
    .mclk_in                  (mclk_in),
    .rst_in                   (rst_in),
    .addr_in                  (addr_in),
    .wdata_in                 (wdata_in),
    .wr_in                    (wr_in),
    .rd_in                    (rd_in),
    .rdata_out                (rdata_out),
    .pin_direction_control_in (dir_in),
    .port_latch_in            (port_in),
    .pwm_output_pin_out       (pin_out),
    .pwm_output_pin_oe_out    (oe_out)
  );

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic bad(input string m);
    failures++;
    $display("BAD %0t %s", $time, m);
  endtask

  task automatic chk8(input byte_t g, input byte_t e, input string m);
    tests_run++;
    if (g !== e) bad($sformatf("%s got %h exp %h", m, g, e));
  endtask

  task automatic chkb(input logic g, input logic e, input string m);
    tests_run++;
    if (g !== e) bad($sformatf("%s got %b exp %b", m, g, e));
  endtask

  task automatic chkn(input int g, input int e, input string m);
    tests_run++;
    if (g != e) bad($sformatf("%s got %0d exp %0d", m, g, e));
  endtask

  task automatic wr(input addr_t a, input byte_t d);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in    <= 1'b0;
  endtask

  task automatic rd(input addr_t a, output byte_t d);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in   <= 1'b0;
    #1 d = rdata_out;
  endtask

  function automatic int ratio(input logic [1:0] p);
    return (p == 2'h0) ? 1 : (p == 2'h1) ? 4 : 16;
  endfunction

  function automatic byte_t mask_of(input addr_t a);
    if (a == `OFF_TCTL_A || a == `OFF_TCTL_B) return `TCTL_MASK;
    if (a == `OFF_UCTL) return `UCTL_MASK;
    if (a == `OFF_TSEL) return `TSEL_MASK;
    return 8'hFF;
  endfunction

  // one pwm setup, then high cycles summed over two whole periods
  task automatic measure(input logic sel, input logic [1:0] pre,
                         input byte_t lim, input base_t duty);
    addr_t tc;
    int    per;
    int    h;
    int    e;
    tc  = sel ? `OFF_TCTL_B : `OFF_TCTL_A;
    per = (lim + 1) * 4 * ratio(pre);
    h   = 0;
    // both timers stop, so no period end moves the shadow early
    wr(`OFF_TCTL_A, 8'h00);
    wr(`OFF_TCTL_B, 8'h00);
    rd(`OFF_DUTY_SH, old);
    wr(`OFF_DUTY_WR, duty[9:2]);
    rd(`OFF_DUTY_SH, got);
    chk8(got, old, "shadow before period end");
    wr(`OFF_UCTL, {2'b00, duty[1:0], 4'hC});
    wr(`OFF_TSEL, {4'h0, sel, 3'h0});
    wr(sel ? `OFF_LIMIT_B : `OFF_LIMIT_A, lim);
    wr(sel ? `OFF_COUNT_B : `OFF_COUNT_A, 8'h00);
    wr(tc, {1'b0, 4'($random(seed)), 1'b1, pre});
    repeat (2 * per) @(posedge mclk_in);
    rd(`OFF_DUTY_SH, got);
    chk8(got, duty[9:2], "shadow after period end");
    wr(`OFF_DUTY_SH, 8'($random(seed)));
    rd(`OFF_DUTY_SH, got);
    chk8(got, duty[9:2], "shadow write in pwm mode");
    repeat (2 * per) begin
      @(posedge mclk_in);
      #1 h += int'(pin_out === 1'b1);
    end
    e = (duty > 4 * lim + 3) ? 2 * per : 2 * duty * ratio(pre);
    chkn(h, e, $sformatf("high cycles p%0d l%0d d%0d", pre, lim, duty));
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #900000;
    bad("run limit reached");
    tally_and_finish;
  end

  initial begin
    byte_t d;
    byte_t lim;
    seed      = 32'he805;
    failures  = 0;
    tests_run = 0;
    rst_in    = 1'b1;
    addr_in   = 4'h0;
    wdata_in  = 8'h00;
    wr_in     = 1'b0;
    rd_in     = 1'b0;
    dir_in    = 1'b1;
    port_in   = 1'b1;
    repeat (8) @(posedge mclk_in);
    rst_in <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      rd(addr_t'(a), got);
      chk8(got, 8'h00, "reset value");
    end
    $display("test reset done");
    for (int a = 0; a < 16; a++) begin
      if (a == `OFF_COUNT_A || a == `OFF_COUNT_B || a == `OFF_DUTY_SH)
        continue;
      d = 8'($random(seed));
      wr(addr_t'(a), d);
      rd(addr_t'(a), got);
      chk8(got, (a > `OFF_TSEL) ? 8'h00 : d & mask_of(addr_t'(a)),
           "rw");
    end
    $display("test registers done");
    for (int i = 0; i < 10; i++) begin
      dir_in  <= 1'($random(seed));
      port_in <= 1'($random(seed));
      wr(`OFF_UCTL, (i == 0) ? 8'h00 : 8'(($unsigned($random(seed)) % 12)));
      @(posedge mclk_in);
      #1 chkb(pin_out, port_in, "pin outside pwm mode");
      chkb(oe_out, ~dir_in, "pin enable");
    end
    $display("test pin mux done");
    dir_in  <= 1'b0;
    port_in <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      measure(1'b0, 2'(p), 8'h02, 10'h000);
      measure(1'b1, 2'(p), 8'h01, 10'h009);
      measure(1'b0, 2'(p), 8'h03, 10'h00F);
    end
    for (int i = 0; i < 12; i++) begin
      lim = 8'($unsigned($random(seed)) % 8);
      measure(1'($random(seed)), 2'($random(seed)), lim,
              10'(1 + $unsigned($random(seed)) % (4 * lim + 3)));
    end
    $display("test pwm waveform done");
    tally_and_finish;
  end
endmodule
